// File: core/rtcx_map.svh
`ifndef RTCX_MAP_SVH
`define RTCX_MAP_SVH
`define RTCX_OFF_STAMP_SS   8'h38
`define RTCX_OFF_CALIB      8'h3C
`define RTCX_OFF_TAMPER     8'h40
`define RTCX_OFF_ALARM_A_SS 8'h44
`define RTCX_OFF_ALARM_B_SS 8'h48
`define RTCX_OFF_BACKUP_LO  8'h50
`define RTCX_OFF_BACKUP_HI  8'h9C
`define RTCX_OFF_STAMP_TIME 8'h30
`define RTCX_OFF_STAMP_DATE 8'h34
`define RTCX_RESET_WORD     32'h0000_0000
`define RTCX_CAL_INSERT_BIT 15
`define RTCX_CAL_WIN8_BIT   14
`define RTCX_CAL_WIN16_BIT  13
`define RTCX_CAL_MASK_MSB   8
`define RTCX_CAL_INSERT_PERIOD 2048
`define RTCX_CAL_CYCLE_BITS 20
`define RTCX_TP_ADRIVE_BIT  18
`define RTCX_TP_SSEL_BIT    17
`define RTCX_TP_ASEL_BIT    16
`define RTCX_TP_PUOFF_BIT   15
`define RTCX_TP_PRCH_MSB    14
`define RTCX_TP_PRCH_LSB    13
`define RTCX_TP_FLT_MSB     12
`define RTCX_TP_FLT_LSB     11
`define RTCX_TP_RATE_MSB    10
`define RTCX_TP_RATE_LSB    8
`define RTCX_TP_TSTAMP_BIT  7
`define RTCX_TP_BPOL_BIT    4
`define RTCX_TP_BEN_BIT     3
`define RTCX_TP_IE_BIT      2
`define RTCX_TP_APOL_BIT    1
`define RTCX_TP_AEN_BIT     0
`define RTCX_TP_WMASK       32'h0007_FF9F
`define RTCX_AL_MSK_MSB     27
`define RTCX_AL_MSK_LSB     24
`define RTCX_AL_WMASK       32'h0F00_7FFF
`define RTCX_CAL_WMASK      32'h0000_E1FF
`define RTCX_SAMPLE_BASE    32768
`endif

// File: core/rtcx_pkg.sv
package rtcx_pkg;
   typedef logic [31:0] rtcx_word_t;
   typedef logic [7:0]  rtcx_addr_t;
   typedef enum logic [1:0] {RTCX_TP_IDLE, RTCX_TP_CHARGE, RTCX_TP_SAMPLE} rtcx_tp_state_t;
endpackage

// File: core/rtcx_backup_mem.sv
`timescale 1ns/100ps
`default_nettype none
module rtcx_backup_mem #(
   parameter int WORDS = 20
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     wipe,
   input  wire logic                     wr_en,
   input  wire logic [4:0]               wr_idx,
   input  wire logic [31:0]              wr_data,
   input  wire logic [4:0]               rd_idx,
   output logic      [31:0]              rd_data
);
   logic [31:0] mem_r [WORDS];
   genvar g;
   // wipe on tamper takes priority over a write in the same cycle
   generate
      for (g = 0; g < WORDS; g++)
      begin : g_word
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               mem_r[g] <= 32'h0000_0000;
            else if (wipe)
               mem_r[g] <= 32'h0000_0000;
            else if (wr_en && wr_idx == 5'(g))
               mem_r[g] <= wr_data;
         end
      end
   endgenerate
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_data <= 32'h0000_0000;
      else if (wipe)
         rd_data <= 32'h0000_0000;
      else if (rd_idx < 5'(WORDS))
         rd_data <= mem_r[rd_idx];
      else
         rd_data <= 32'h0000_0000;
   end
endmodule
`default_nettype wire

// File: core/rtcx_tamper_stamp.sv
`include "rtcx_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rtcx_tamper_stamp #(
   parameter int BACKUP_WORDS = 20,
   parameter int SAMPLE_BASE  = `RTCX_SAMPLE_BASE
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire rtcx_pkg::rtcx_addr_t reg_addr,
   input  wire rtcx_pkg::rtcx_word_t reg_wdata,
   output rtcx_pkg::rtcx_word_t      reg_rdata,
   input  wire logic [15:0]          subsecond_count,
   input  wire logic [22:0]          calendar_time,
   input  wire logic [12:0]          calendar_date,
   input  wire logic                 stamp_enable,
   input  wire logic                 init_mode_flag,
   input  wire logic                 alarm_a_enable,
   input  wire logic                 alarm_b_enable,
   input  wire logic                 stamp_flag_clear,
   input  wire logic [1:0]           tamper_flag_clear,
   input  wire logic                 pin_first,
   input  wire logic                 pin_second,
   input  wire logic                 rtc_source_clock,
   output logic                      calendar_tick,
   output logic                      stamp_flag,
   output logic [1:0]                tamper_detect_flag,
   output logic                      tamper_irq,
   output logic                      alarm_a_subsec_match,
   output logic                      alarm_b_subsec_match,
   output logic                      alarm_pin_drive_type,
   output logic                      tamper_pullup_en
);
   import rtcx_pkg::*;

   rtcx_word_t     calib_r, tamp_r, alm_a_r, alm_b_r;
   logic [15:0]    stamp_ss_r;
   logic [22:0]    stamp_time_r;
   logic [12:0]    stamp_date_r;
   logic [1:0]     pin_s1_r, pin_s2_r, pin_d_r;
   logic           src_s1_r, src_s2_r, src_d_r, stamp_pin_d_r;
   logic           pulse_in;
   logic [19:0]    cyc_r;
   logic [10:0]    ins_cnt_r;
   logic           insert_pend_r;
   logic [8:0]     mask_eff;
   logic [8:0]     mask_rev;
   logic           mask_hit;
   logic [14:0]    samp_cnt_r;
   logic [14:0]    samp_period;
   logic [3:0]     chg_cnt_r;
   logic [3:0]     chg_len;
   rtcx_tp_state_t tp_state_r;
   logic [3:0]     lvl_cnt_r [2];
   logic [3:0]     lvl_need;
   logic [1:0]     tp_event;
   logic           edge_mode;
   logic           use_charge;
   logic           stamp_set;
   logic           bk_wr;
   logic [4:0]     bk_idx;
   rtcx_word_t     bk_rdata;
   logic           bk_sel_r;
   rtcx_word_t     rdata_r;
   logic [1:0]     tp_en;
   logic [1:0]     tp_pol;
   logic [1:0]     tp_pin;

   // pins and the source clock are asynchronous, two flops first
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_s1_r <= 2'h0;
         pin_s2_r <= 2'h0;
         src_s1_r <= 1'b0;
         src_s2_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= {pin_second, pin_first};
         pin_s2_r <= pin_s1_r;
         src_s1_r <= rtc_source_clock;
         src_s2_r <= src_s1_r;
      end
   end

   // stamp pin history gives a rising edge, so a held pin cannot block the clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         src_d_r       <= 1'b0;
         stamp_pin_d_r <= 1'b0;
      end
      else
      begin
         src_d_r       <= src_s2_r;
         stamp_pin_d_r <= pin_s2_r[tamp_r[`RTCX_TP_SSEL_BIT]];
      end
   end
   assign pulse_in = src_s2_r & ~src_d_r;

   // window bits force low mask bits
   always_comb
   begin
      mask_eff = calib_r[`RTCX_CAL_MASK_MSB:0];
      if (calib_r[`RTCX_CAL_WIN8_BIT])
         mask_eff[1:0] = 2'b00;
      if (calib_r[`RTCX_CAL_WIN16_BIT])
         mask_eff[0] = 1'b0;
   end

   // bit-reversed cycle high bits spread masked pulses evenly across the cycle
   always_comb
   begin
      for (int i = 0; i < 9; i++)
         mask_rev[i] = cyc_r[19 - i];
   end
   // mask count pulses dropped per 2^20
   assign mask_hit = (cyc_r[10:0] == 11'h000) && (mask_rev < mask_eff);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cyc_r     <= 20'h00000;
         ins_cnt_r <= 11'h000;
      end
      else if (pulse_in)
      begin
         cyc_r     <= cyc_r + 20'h00001;
         ins_cnt_r <= ins_cnt_r + 11'h001;
      end
   end

   // one extra pulse every 2048 source pulses
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         insert_pend_r <= 1'b0;
      else if (pulse_in && ins_cnt_r == 11'h7FF && calib_r[`RTCX_CAL_INSERT_BIT])
         insert_pend_r <= 1'b1;
      else if (!pulse_in)
         insert_pend_r <= 1'b0;
   end

   // net result is inserts minus masks over the window
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         calendar_tick <= 1'b0;
      else
         calendar_tick <= (pulse_in && !mask_hit) || (insert_pend_r && !pulse_in);
   end

   assign edge_mode  = tamp_r[`RTCX_TP_FLT_MSB:`RTCX_TP_FLT_LSB] == 2'b00;
   assign use_charge = !edge_mode && !tamp_r[`RTCX_TP_PUOFF_BIT];
   assign samp_period = 15'((SAMPLE_BASE >> tamp_r[`RTCX_TP_RATE_MSB:`RTCX_TP_RATE_LSB]) - 1);
   // precharge of 1, 2, 4 or 8 source clock pulses
   assign chg_len  = 4'(4'h1 << tamp_r[`RTCX_TP_PRCH_MSB:`RTCX_TP_PRCH_LSB]);
   assign lvl_need = 4'(4'h1 << tamp_r[`RTCX_TP_FLT_MSB:`RTCX_TP_FLT_LSB]);
   assign tp_en  = {tamp_r[`RTCX_TP_BEN_BIT], tamp_r[`RTCX_TP_AEN_BIT]};
   assign tp_pol = {tamp_r[`RTCX_TP_BPOL_BIT], tamp_r[`RTCX_TP_APOL_BIT]};
   // input select chooses the pin for tamper a
   assign tp_pin = {pin_s2_r[1], tamp_r[`RTCX_TP_ASEL_BIT] ? pin_s2_r[1] : pin_s2_r[0]};

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tp_state_r <= RTCX_TP_IDLE;
         samp_cnt_r <= 15'h0000;
         chg_cnt_r  <= 4'h0;
      end
      else
      begin
         unique case (tp_state_r)
            RTCX_TP_IDLE:
            begin
               if (pulse_in && tp_en != 2'b00)
               begin
                  if (samp_cnt_r >= samp_period)
                  begin
                     samp_cnt_r <= 15'h0000;
                     chg_cnt_r  <= 4'h1;
                     tp_state_r <= use_charge ? RTCX_TP_CHARGE : RTCX_TP_SAMPLE;
                  end
                  else
                     samp_cnt_r <= samp_cnt_r + 15'h0001;
               end
            end
            RTCX_TP_CHARGE:
            begin
               if (pulse_in)
               begin
                  if (chg_cnt_r >= chg_len)
                     tp_state_r <= RTCX_TP_SAMPLE;
                  else
                     chg_cnt_r <= chg_cnt_r + 4'h1;
               end
            end
            RTCX_TP_SAMPLE:
               tp_state_r <= RTCX_TP_IDLE;
         endcase
      end
   end
   assign tamper_pullup_en = tp_state_r == RTCX_TP_CHARGE;

   // polarity by mode; level count 2, 4 or 8
   genvar t;
   generate
      for (t = 0; t < 2; t++)
      begin : g_tp
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               pin_d_r[t] <= 1'b0;
            else if (tp_state_r == RTCX_TP_SAMPLE)
               pin_d_r[t] <= tp_pin[t];
         end
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               lvl_cnt_r[t] <= 4'h0;
            else if (!tp_en[t] || edge_mode)
               lvl_cnt_r[t] <= 4'h0;
            else if (tp_state_r == RTCX_TP_SAMPLE)
               lvl_cnt_r[t] <= (tp_pin[t] == tp_pol[t]) ?
                               ((lvl_cnt_r[t] < lvl_need) ? lvl_cnt_r[t] + 4'h1 : lvl_need)
                               : 4'h0;
         end
         always_comb
         begin
            tp_event[t] = 1'b0;
            if (tp_en[t] && tp_state_r == RTCX_TP_SAMPLE)
            begin
               if (edge_mode)
                  tp_event[t] = tp_pol[t] ? (pin_d_r[t] && !tp_pin[t])
                                          : (!pin_d_r[t] && tp_pin[t]);
               else
                  tp_event[t] = (tp_pin[t] == tp_pol[t]) && (lvl_cnt_r[t] + 4'h1 == lvl_need);
            end
         end
         // event sets the flag, set wins over clear
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               tamper_detect_flag[t] <= 1'b0;
            else if (tp_event[t])
               tamper_detect_flag[t] <= 1'b1;
            else if (tamper_flag_clear[t])
               tamper_detect_flag[t] <= 1'b0;
         end
      end
   endgenerate

   assign tamper_irq = tamp_r[`RTCX_TP_IE_BIT] && (tamper_detect_flag != 2'b00);

   // tamper may raise the stamp flag even with stamping off
   assign stamp_set = (stamp_enable && pin_s2_r[tamp_r[`RTCX_TP_SSEL_BIT]] && !stamp_pin_d_r)
                      || (tamp_r[`RTCX_TP_TSTAMP_BIT] && tp_event != 2'b00);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         stamp_flag <= 1'b0;
      else if (stamp_set)
         stamp_flag <= 1'b1;
      else if (stamp_flag_clear)
         stamp_flag <= 1'b0;
   end

   // capture count; capture time; clear with the flag
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stamp_ss_r   <= 16'h0000;
         stamp_time_r <= 23'h000000;
         stamp_date_r <= 13'h0000;
      end
      else if (stamp_set && !stamp_flag)
      begin
         stamp_ss_r   <= subsecond_count;
         stamp_time_r <= calendar_time;
         stamp_date_r <= calendar_date;
      end
      else if (stamp_flag_clear && !stamp_set)
      begin
         stamp_ss_r   <= 16'h0000;
         stamp_time_r <= 23'h000000;
         stamp_date_r <= 13'h0000;
      end
   end

   // mask width n compares low n bits; bit 15 excluded
   function automatic logic ss_match(input logic [31:0] a, input logic [15:0] c);
      logic [14:0] m;
      m = 15'((16'h0001 << a[`RTCX_AL_MSK_MSB:`RTCX_AL_MSK_LSB]) - 16'h0001);
      return ((a[14:0] ^ c[14:0]) & m) == 15'h0000;
   endfunction

   // each alarm against the live count
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         alarm_a_subsec_match <= 1'b0;
         alarm_b_subsec_match <= 1'b0;
      end
      else
      begin
         alarm_a_subsec_match <= ss_match(alm_a_r, subsecond_count);
         alarm_b_subsec_match <= ss_match(alm_b_r, subsecond_count);
      end
   end

   // drive type straight from its bit
   assign alarm_pin_drive_type = tamp_r[`RTCX_TP_ADRIVE_BIT];

   // word accesses only, no byte lanes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         calib_r <= `RTCX_RESET_WORD;
         tamp_r  <= `RTCX_RESET_WORD;
      end
      else if (reg_wr && reg_addr == `RTCX_OFF_CALIB)
         calib_r <= reg_wdata & `RTCX_CAL_WMASK;
      else if (reg_wr && reg_addr == `RTCX_OFF_TAMPER)
         tamp_r <= reg_wdata & `RTCX_TP_WMASK;
   end

   // alarm writes held off while alarm runs outside init
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         alm_a_r <= `RTCX_RESET_WORD;
         alm_b_r <= `RTCX_RESET_WORD;
      end
      else if (reg_wr && reg_addr == `RTCX_OFF_ALARM_A_SS && (!alarm_a_enable || init_mode_flag))
         alm_a_r <= reg_wdata & `RTCX_AL_WMASK;
      else if (reg_wr && reg_addr == `RTCX_OFF_ALARM_B_SS && (!alarm_b_enable || init_mode_flag))
         alm_b_r <= reg_wdata & `RTCX_AL_WMASK;
   end

   assign bk_idx = 5'((reg_addr - `RTCX_OFF_BACKUP_LO) >> 2);
   assign bk_wr  = reg_wr && reg_addr >= `RTCX_OFF_BACKUP_LO && reg_addr <= `RTCX_OFF_BACKUP_HI;

   // backup words wiped while a tamper flag stands
   rtcx_backup_mem #(
      .WORDS   (BACKUP_WORDS)
   ) u_backup (
      .clk     (clk),
      .rst     (rst),
      .wipe    (tamper_detect_flag != 2'b00 || tp_event != 2'b00),
      .wr_en   (bk_wr),
      .wr_idx  (bk_idx),
      .wr_data (reg_wdata),
      .rd_idx  (bk_idx),
      .rd_data (bk_rdata)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_r  <= `RTCX_RESET_WORD;
         bk_sel_r <= 1'b0;
      end
      else
      begin
         bk_sel_r <= reg_rd && reg_addr >= `RTCX_OFF_BACKUP_LO && reg_addr <= `RTCX_OFF_BACKUP_HI;
         rdata_r  <= `RTCX_RESET_WORD;
         if (reg_rd)
         begin
            unique case (reg_addr)
               `RTCX_OFF_STAMP_SS:   rdata_r <= {16'h0000, stamp_ss_r};
               `RTCX_OFF_STAMP_TIME: rdata_r <= {9'h000, stamp_time_r};
               `RTCX_OFF_STAMP_DATE: rdata_r <= {19'h00000, stamp_date_r[12:8], 2'b00,
                                                 stamp_date_r[5:0]};
               `RTCX_OFF_CALIB:      rdata_r <= calib_r;
               `RTCX_OFF_TAMPER:     rdata_r <= tamp_r;
               `RTCX_OFF_ALARM_A_SS: rdata_r <= alm_a_r;
               `RTCX_OFF_ALARM_B_SS: rdata_r <= alm_b_r;
               default:              rdata_r <= `RTCX_RESET_WORD;
            endcase
         end
      end
   end
   assign reg_rdata = bk_sel_r ? bk_rdata : rdata_r;
endmodule
`default_nettype wire

// File: testbench/rtcx_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module rtcx_pin_model (
   input  wire logic [1:0] level,
   output logic            pin_first,
   output logic            pin_second,
   output logic            rtc_source_clock
);
   // free-running oscillator, phase unrelated to the bus clock
   initial
   begin
      rtc_source_clock = 1'b0;
      #37;
      forever #100 rtc_source_clock = ~rtc_source_clock;
   end
   // pins move a little after the command so no edge lines up with the bus clock
   assign #3 pin_first  = level[0];
   assign #3 pin_second = level[1];
endmodule
`default_nettype wire

// File: testbench/rtcx_tamper_stamp_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtcx_map.svh"
module rtcx_tamper_stamp_sva #(
   parameter int SAMPLE_BASE = 256
) (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire rtcx_pkg::rtcx_addr_t reg_addr,
   input wire rtcx_pkg::rtcx_word_t reg_wdata,
   input wire rtcx_pkg::rtcx_word_t reg_rdata,
   input wire logic [15:0]          subsecond_count,
   input wire logic                 init_mode_flag,
   input wire logic                 alarm_a_enable,
   input wire logic                 alarm_b_enable,
   input wire logic                 stamp_flag,
   input wire logic [1:0]           tamper_detect_flag,
   input wire logic                 tamper_irq,
   input wire logic                 alarm_a_subsec_match,
   input wire logic                 alarm_b_subsec_match,
   input wire logic                 alarm_pin_drive_type,
   input wire logic                 tamper_pullup_en
);
   import rtcx_pkg::*;
   rtcx_word_t tamp_r;
   rtcx_word_t al_a_r;
   rtcx_word_t al_b_r;
   logic       exp_a;
   logic       exp_b;

   // count bit 15 never takes part, so only 15 bits are masked
   function automatic logic sub_match(input rtcx_word_t r, input logic [15:0] sc);
      logic [14:0] m;
      m = 15'((32'h1 << r[27:24]) - 32'h1);
      return ((r[14:0] ^ sc[14:0]) & m) == 15'h0;
   endfunction

   assign exp_a = sub_match(al_a_r, subsecond_count);
   assign exp_b = sub_match(al_b_r, subsecond_count);

   // shadow of the tamper and alarm words; refused alarm writes are skipped
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tamp_r <= 32'h0;
         al_a_r <= 32'h0;
         al_b_r <= 32'h0;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `RTCX_OFF_TAMPER)
            tamp_r <= reg_wdata & `RTCX_TP_WMASK;
         if (reg_addr == `RTCX_OFF_ALARM_A_SS && (!alarm_a_enable || init_mode_flag))
            al_a_r <= reg_wdata & `RTCX_AL_WMASK;
         if (reg_addr == `RTCX_OFF_ALARM_B_SS && (!alarm_b_enable || init_mode_flag))
            al_b_r <= reg_wdata & `RTCX_AL_WMASK;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_drive_type;
      alarm_pin_drive_type == tamp_r[`RTCX_TP_ADRIVE_BIT];
   endproperty
   a_drive_type: assert property (p_drive_type)
      else $error("alarm drive type differs from its control bit");
   property p_irq;
      tamper_irq == ((|tamper_detect_flag) && tamp_r[`RTCX_TP_IE_BIT]);
   endproperty
   a_irq: assert property (p_irq)
      else $error("tamper request not gated by flags and enable");
   property p_precharge;
      $rose(tamper_pullup_en) |-> !$past(tamp_r[15]) && ($past(tamp_r[12:11]) != 2'b00);
   endproperty
   a_precharge: assert property (p_precharge)
      else $error("pull-up charge started while disabled");
   property p_flag_a;
      $rose(tamper_detect_flag[0]) |-> $past(tamp_r[`RTCX_TP_AEN_BIT]);
   endproperty
   a_flag_a: assert property (p_flag_a)
      else $error("first tamper flag set while disabled");
   property p_flag_b;
      $rose(tamper_detect_flag[1]) |-> $past(tamp_r[`RTCX_TP_BEN_BIT]);
   endproperty
   a_flag_b: assert property (p_flag_b)
      else $error("second tamper flag set while disabled");
   sequence s_event_stamps;
      $rose(|tamper_detect_flag) && $past(tamp_r[`RTCX_TP_TSTAMP_BIT]);
   endsequence
   property p_tamper_stamp;
      s_event_stamps |-> ##[0:2] stamp_flag;
   endproperty
   a_tamper_stamp: assert property (p_tamper_stamp)
      else $error("tamper event did not raise the stamp flag");
   property p_alarm_a;
      !$past(rst) |-> alarm_a_subsec_match == $past(exp_a);
   endproperty
   a_alarm_a: assert property (p_alarm_a)
      else $error("first alarm subsecond match wrong");
   property p_alarm_b;
      !$past(rst) |-> alarm_b_subsec_match == $past(exp_b);
   endproperty
   a_alarm_b: assert property (p_alarm_b)
      else $error("second alarm subsecond match wrong");
   property p_rd_tamper;
      reg_rd && reg_addr == `RTCX_OFF_TAMPER |=> reg_rdata == $past(tamp_r);
   endproperty
   a_rd_tamper: assert property (p_rd_tamper)
      else $error("tamper word read back wrong");
   property p_unmapped;
      reg_rd && reg_addr == 8'h4C |=> reg_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");

   c_pullup: cover property ($rose(tamper_pullup_en));
   c_irq: cover property ($rose(tamper_irq));
   c_alarm: cover property ($rose(alarm_a_subsec_match));
endmodule
bind rtcx_tamper_stamp rtcx_tamper_stamp_sva #(.SAMPLE_BASE(SAMPLE_BASE)) i_sva (
   .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .subsecond_count(subsecond_count),
   .init_mode_flag(init_mode_flag), .alarm_a_enable(alarm_a_enable),
   .alarm_b_enable(alarm_b_enable), .stamp_flag(stamp_flag),
   .tamper_detect_flag(tamper_detect_flag), .tamper_irq(tamper_irq),
   .alarm_a_subsec_match(alarm_a_subsec_match), .alarm_b_subsec_match(alarm_b_subsec_match),
   .alarm_pin_drive_type(alarm_pin_drive_type), .tamper_pullup_en(tamper_pullup_en));
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import rtcx_pkg::*;
   logic        clk, rst, reg_wr, reg_rd, stamp_enable, init_mode_flag;
   logic        alarm_a_enable, alarm_b_enable, stamp_flag_clear, pin_first, pin_second;
   logic        rtc_source_clock, calendar_tick, stamp_flag, tamper_irq, tamper_pullup_en;
   logic        alarm_a_subsec_match, alarm_b_subsec_match, alarm_pin_drive_type;
   logic [1:0]  tamper_flag_clear, tamper_detect_flag, level;
   rtcx_addr_t  reg_addr;
   rtcx_word_t  reg_wdata, reg_rdata, cfg;
   logic [15:0] subsecond_count;
   logic [22:0] calendar_time;
   logic [12:0] calendar_date;
   int          errors, checked, ticks;
   rtcx_addr_t  addrs [8] = '{8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h50, 8'h9C, 8'h4C};

   rtcx_tamper_stamp #(.SAMPLE_BASE(256)) i_dut (
      .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .subsecond_count(subsecond_count),
      .calendar_time(calendar_time), .calendar_date(calendar_date),
      .stamp_enable(stamp_enable), .init_mode_flag(init_mode_flag),
      .alarm_a_enable(alarm_a_enable), .alarm_b_enable(alarm_b_enable),
      .stamp_flag_clear(stamp_flag_clear), .tamper_flag_clear(tamper_flag_clear),
      .pin_first(pin_first), .pin_second(pin_second), .rtc_source_clock(rtc_source_clock),
      .calendar_tick(calendar_tick), .stamp_flag(stamp_flag),
      .tamper_detect_flag(tamper_detect_flag), .tamper_irq(tamper_irq),
      .alarm_a_subsec_match(alarm_a_subsec_match), .alarm_b_subsec_match(alarm_b_subsec_match),
      .alarm_pin_drive_type(alarm_pin_drive_type), .tamper_pullup_en(tamper_pullup_en));
   rtcx_pin_model i_pins (.level(level), .pin_first(pin_first), .pin_second(pin_second),
      .rtc_source_clock(rtc_source_clock));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // strobes drop a cycle before the next access so no signal changes twice at once
   task automatic wr(input rtcx_addr_t a, input rtcx_word_t d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      step(1);
      reg_wr = 1'b0;
      step(1);
   endtask
   task automatic rd(input rtcx_addr_t a, input rtcx_word_t exp);
      reg_rd = 1'b1;
      reg_addr = a;
      step(1);
      reg_rd = 1'b0;
      check(reg_rdata, exp);
      step(1);
   endtask
   task automatic clear(input logic st, input logic [1:0] tp);
      stamp_flag_clear = st;
      tamper_flag_clear = tp;
      step(1);
      stamp_flag_clear = 1'b0;
      tamper_flag_clear = 2'b00;
      step(2);
   endtask
   task automatic wait_bit(input int sel);
      int k;
      for (k = 0; k < 2000; k++)
      begin
         if ((sel == 0 ? tamper_detect_flag[0] : stamp_flag) === 1'b1)
            break;
         step(1);
      end
      if (k == 2000)
      begin
         errors++;
         $display("ERROR %0t: wait timed out", $time);
         summarize();
      end
      step(2);
   endtask

   initial
   begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b10, 1'b0, 8'h00, 32'h0};
      {stamp_enable, init_mode_flag, alarm_a_enable, alarm_b_enable} = 4'h0;
      {stamp_flag_clear, tamper_flag_clear, level} = 5'h00;
      {subsecond_count, calendar_time, calendar_date} = {16'hBEEF, 23'h52_3456, 13'h12E9};
      step(6);
      rst = 1'b0;
      foreach (addrs[i]) rd(addrs[i], 32'h0);
      wr(8'h3C, 32'hFFFF_81FF);
      rd(8'h3C, 32'h0000_81FF);
      wr(8'h40, 32'hFFF8_0060);
      rd(8'h40, 32'h0);
      wr(8'h40, 32'h0004_0000);
      check(alarm_pin_drive_type, 1'b1);
      wr(8'h40, 32'h0);
      check(alarm_pin_drive_type, 1'b0);
      $display("test registers done");
      for (int c = 0; c < 3; c++)
      begin
         wr(8'h3C, (c == 0) ? 32'h0 : (c == 1) ? 32'h0000_8000 : 32'h0000_01FF);
         ticks = 0;
         repeat (16384)
         begin
            step(1);
            ticks += (calendar_tick === 1'b1) ? 1 : 0;
         end
         check(32'(ticks >= 4095 + (c == 1) - 3 * (c == 2)
                   && ticks <= 4097 + 3 * (c == 1) - 2 * (c == 2)), 32'h1);
      end
      $display("test calibration done");
      stamp_enable = 1'b1;
      wr(8'h40, 32'h0002_0000);
      level[0] = 1'b1;
      step(60);
      check(stamp_flag, 1'b0);
      level[1] = 1'b1;
      wait_bit(1);
      rd(8'h38, 32'h0000_BEEF);
      rd(8'h34, 32'h0000_1229);
      rd(8'h30, 32'h0052_3456);
      clear(1'b1, 2'b00);
      rd(8'h38, 32'h0);
      stamp_enable = 1'b0;
      wr(8'h40, 32'h0);
      level = 2'b00;
      step(8);
      $display("test stamp done");
      for (int p = 0; p < 2; p++)
      begin
         cfg = (p == 0) ? 32'h0000_0785 : 32'h0000_0783;
         wr(8'h40, 32'h0);
         level[0] = (p == 1);
         step(8);
         wr(8'h40, cfg);
         wr(8'h50, 32'hA5A5_0001);
         rd(8'h50, 32'hA5A5_0001);
         level[0] = (p == 0);
         wait_bit(0);
         check(tamper_irq, p == 0);
         check(stamp_flag, 1'b1);
         rd(8'h38, 32'h0000_BEEF);
         rd(8'h50, 32'h0);
         clear(1'b1, 2'b01);
         check(tamper_detect_flag, 2'b00);
      end
      wr(8'h9C, 32'h1234_5678);
      rd(8'h9C, 32'h1234_5678);
      wr(8'h40, 32'h0);
      level = 2'b01;
      step(8);
      wr(8'h40, 32'h0001_6F03);
      step(100);
      check(tamper_detect_flag, 2'b00);
      level[1] = 1'b1;
      wait_bit(0);
      wr(8'h40, 32'h0);
      clear(1'b1, 2'b01);
      $display("test tamper done");
      subsecond_count = 16'h8005;
      wr(8'h44, 32'h0400_0005);
      check(alarm_a_subsec_match, 1'b1);
      wr(8'h44, 32'h0F00_0006);
      check(alarm_a_subsec_match, 1'b0);
      alarm_a_enable = 1'b1;
      wr(8'h44, 32'h0F00_0005);
      rd(8'h44, 32'h0F00_0006);
      init_mode_flag = 1'b1;
      wr(8'h44, 32'h0F00_0005);
      check(alarm_a_subsec_match, 1'b1);
      wr(8'h48, 32'hFFFF_FFFF);
      rd(8'h48, 32'h0F00_7FFF);
      check(alarm_b_subsec_match, 1'b0);
      $display("test alarm done");
      summarize();
   end
endmodule
`default_nettype wire
